// *** gooc_defs.svh ***
`ifndef GOOC_DEFS_SVH
`define GOOC_DEFS_SVH

// Register byte offsets on APB.
`define GOOC_REFA_OFS 12'h000
`define GOOC_REF_CLOCK_OUT_B_OFS 12'h004
`define GOOC_RXCFG_OFS 12'h008
`define GOOC_TXEN_OFS 12'h00C
`define GOOC_STAT_OFS 12'h010

// Field positions in the reference configuration registers.
`define GOOC_REF_SEL_LSB 0
`define GOOC_REF_CH_LSB 8
`define GOOC_REF_FREQ_BIT 5
`define GOOC_REF_OE_BIT 6
// Spare bits of reference A that choose the receive word shown on reads.
`define GOOC_RXSEL_LSB 16

// Field positions in a per-channel receive configuration word.
`define GOOC_TERM_LSB 0
`define GOOC_R120_BIT 4
`define GOOC_RXCH_LSB 8

// Reset values.
`define GOOC_REFA_RST 32'h0000_0000
`define GOOC_REF_CLOCK_OUT_B_RST 32'h0000_0000
`define GOOC_TXEN_RST 22'h3F_FFFF

// Source select encodings of reference B.
`define GOOC_SRC_RECOV 2'h0
`define GOOC_SRC_EXT 2'h1
`define GOOC_SRC_FREE 2'h2

// Free-running clock divider half period in pclk cycles, less one.
`define GOOC_FREE_HALF 8'h0C
`endif

// *** gooc_pkg.sv ***
package gooc_pkg;
  // APB request bundle.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } gooc_apb_s;

  // Whole state of the block.
  typedef struct packed {
    logic [31:0] refa_cfg;
    logic [31:0] ref_clock_out_b_cfg;
    logic [21:0][4:0] rx_cfg;
    logic [21:0] tx_drv_en;
    logic [7:0] free_cnt;
    logic free_clk;
    logic ref_b_out;
    logic ref_b_oe;
    logic [21:0] rx_hiz;
    logic [21:0][2:0] rx_term;
    logic [21:0] rx_r120;
    logic [21:0] drv_oe;
    logic [1:0] vcom_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } gooc_state_s;
endpackage

// *** gooc_top.sv ***
// Register access over APB and the address map were left to the implementer.
`include "gooc_defs.svh"

module gooc_top #(
  parameter int NCH = 22
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources.
  input wire logic [21:0] recovered_clk,
  input wire logic ext_clock_in_a,
  input wire logic ext_clock_in_b,
  // Board control pins.
  input wire logic receive_impedance_pin,
  input wire logic output_enable_pin,
  input wire logic common_mode_enable,
  input wire logic rx_differential_mode,
  // Pin controls.
  output logic ref_clock_out_b,
  output logic ref_b_oe,
  output logic [21:0] rx_hiz,
  output logic [21:0][2:0] rx_term,
  output logic [21:0] rx_internal_120_ohm,
  output logic [21:0] line_drv_oe,
  output logic [1:0] common_mode_voltage_out_oe,
  output logic input_a_freq_select,
  output logic input_b_freq_select
);
  // Current and next state of the whole block.
  gooc_pkg::gooc_state_s s_q;
  gooc_pkg::gooc_state_s s_d;
  // Channel whose receive word the read port shows.
  logic [4:0] rx_sel;

  // Register index of a bus address; zero marks an address with no register.
  // One decode serves the error flag, the write path and the read path, so the
  // three can never disagree about which addresses exist.
  function automatic logic [2:0] dec(input logic [11:0] a);
    case (a)
      `GOOC_REFA_OFS: dec = 3'h1;
      `GOOC_REF_CLOCK_OUT_B_OFS: dec = 3'h2;
      `GOOC_RXCFG_OFS: dec = 3'h3;
      `GOOC_TXEN_OFS: dec = 3'h4;
      `GOOC_STAT_OFS: dec = 3'h5;
      default: dec = 3'h0;
    endcase
  endfunction

  // True when a channel number names one of the fitted channels.
  // Numbers past the last channel are refused rather than wrapped, so a stray
  // write can never land on a channel that software did not mean.
  function automatic logic ch_ok(input logic [4:0] c);
    ch_ok = (c < 5'(NCH));
  endfunction

  // Level that reference B shows next, picked by its configuration word.
  // All three sources are sampled on pclk, so the output carries them one cycle
  // late and at pclk resolution; it is a monitor path, not a low-jitter one.
  // A channel number past the last channel gives a steady low, never an unknown.
  function automatic logic src_pick(
    input logic [31:0] cfg,
    input logic [21:0] rec,
    input logic ext_b,
    input logic free
  );
    logic [4:0] c;
    c = cfg[`GOOC_REF_CH_LSB +: 5];
    case (cfg[`GOOC_REF_SEL_LSB +: 2])
      `GOOC_SRC_RECOV: src_pick = ch_ok(c) ? rec[c] : 1'b0;
      `GOOC_SRC_EXT: src_pick = ext_b;
      default: src_pick = free;
    endcase
  endfunction

  // The read port shows one receive word at a time. Spare bits of reference A
  // choose which, since a written word carries its own channel number and a
  // read has no data to carry one in.
  assign rx_sel = s_q.refa_cfg[`GOOC_RXSEL_LSB +: 5];

  // Next state: bus access, clock pick and pin overrides.
  always_comb
  begin
    logic acc;
    logic [4:0] rch;
    acc = 1'b0;
    rch = 5'h00;
    s_d = s_q;

    // A transfer is taken once, on its first access cycle: pready rises on the
    // next edge for exactly one cycle and blocks a second take of the same
    // request. Every transfer therefore sees one wait state, which keeps the
    // read mux out of the path from paddr to prdata.
    acc = psel && penable && !s_q.pready;
    s_d.pready = acc;
    s_d.pslverr = acc && (dec(paddr) == 3'h0);

    // Writes. Unmapped addresses and the read-only status word change nothing.
    if (acc && pwrite)
    begin
      case (dec(paddr))
        3'h1: s_d.refa_cfg = pwdata;
        3'h2: s_d.ref_clock_out_b_cfg = pwdata;
        3'h3:
        begin
          // The word names its own channel; out-of-range channels are dropped.
          rch = pwdata[`GOOC_RXCH_LSB +: 5];
          if (ch_ok(rch))
            s_d.rx_cfg[rch] = pwdata[`GOOC_R120_BIT:`GOOC_TERM_LSB];
        end
        // Driver enables are plain storage; the pin gates them further down.
        3'h4: s_d.tx_drv_en = pwdata[21:0];
        default: s_d.tx_drv_en = s_q.tx_drv_en;
      endcase
    end

    // Reads. Data is captured on the taking edge and stands with pready.
    // The status word shows the common-mode, output enable and impedance pins as sampled on that edge.
    if (acc && !pwrite)
    begin
      case (dec(paddr))
        3'h1: s_d.prdata = s_q.refa_cfg;
        3'h2: s_d.prdata = s_q.ref_clock_out_b_cfg;
        3'h3: s_d.prdata = ch_ok(rx_sel) ? {27'h000_0000, s_q.rx_cfg[rx_sel]} : 32'h0000_0000;
        3'h4: s_d.prdata = {10'h000, s_q.tx_drv_en};
        3'h5: s_d.prdata = {29'h000_0000, common_mode_enable, output_enable_pin, receive_impedance_pin};
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end

    // Free-running source: a divider that never stops, so switching reference B
    // to it shows a clock at once instead of waiting for a start-up.
    // Its period is twice the half count plus two, in pclk cycles.
    if (s_q.free_cnt == `GOOC_FREE_HALF)
    begin
      s_d.free_cnt = 8'h00;
      s_d.free_clk = !s_q.free_clk;
    end
    else
    begin
      s_d.free_cnt = s_q.free_cnt + 8'h01;
    end

    // Reference B: source pick and output enable. The enable only gates the
    // pad, so the picked clock keeps running and returns without a restart.
    s_d.ref_b_out = src_pick(s_q.ref_clock_out_b_cfg, recovered_clk, ext_clock_in_b, s_q.free_clk);
    s_d.ref_b_oe = s_q.ref_clock_out_b_cfg[`GOOC_REF_OE_BIT];

    // Receive termination. The stored settings are only masked while the
    // impedance pin overrides them, so they return unchanged when it rises.
    // Single-ended mode never overrides; the pin is meant to be left open there.
    for (int i = 0; i < NCH; i++)
    begin
      s_d.rx_hiz[i] = rx_differential_mode && !receive_impedance_pin;
      s_d.rx_term[i] = s_d.rx_hiz[i] ? 3'h0 : s_q.rx_cfg[i][`GOOC_TERM_LSB +: 3];
      s_d.rx_r120[i] = s_d.rx_hiz[i] ? 1'b0 : s_q.rx_cfg[i][`GOOC_R120_BIT];
    end

    // Line drivers. Only the pad enable sees the pin; the per-driver enable
    // register and all transmit state run on, so a protection switch-over
    // needs no reconfiguration afterwards.
    for (int i = 0; i < NCH; i++)
    begin
      s_d.drv_oe[i] = output_enable_pin && s_q.tx_drv_en[i];
    end

    // Common-mode outputs follow their enable pin on both pads.
    s_d.vcom_oe = {2{common_mode_enable}};
  end

  // State register. Reset leaves every pad released and both reference words
  // cleared; the driver enables reset on so that the pin alone rules them.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.refa_cfg <= `GOOC_REFA_RST;
      s_q.ref_clock_out_b_cfg <= `GOOC_REF_CLOCK_OUT_B_RST;
      s_q.tx_drv_en <= `GOOC_TXEN_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Bus response.
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;

  // Reference B pad and its enable.
  assign ref_clock_out_b = s_q.ref_b_out;
  assign ref_b_oe = s_q.ref_b_oe;

  // Receive termination controls.
  assign rx_hiz = s_q.rx_hiz;
  assign rx_term = s_q.rx_term;
  assign rx_internal_120_ohm = s_q.rx_r120;

  // Line driver and common-mode pad enables.
  assign line_drv_oe = s_q.drv_oe;
  assign common_mode_voltage_out_oe = s_q.vcom_oe;

  // Frequency select bits go to the external clock input stages as stored;
  // the host keeps them matched to what is wired to each input.
  assign input_a_freq_select = s_q.refa_cfg[`GOOC_REF_FREQ_BIT];
  assign input_b_freq_select = s_q.ref_clock_out_b_cfg[`GOOC_REF_FREQ_BIT];
endmodule

// *** gooc_props.sv ***
module gooc_props (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Board pins.
  input wire logic receive_impedance_pin,
  input wire logic output_enable_pin,
  input wire logic common_mode_enable,
  input wire logic rx_differential_mode,
  // Pin controls.
  input wire logic [21:0] rx_hiz,
  input wire logic [21:0] rx_internal_120_ohm,
  input wire logic [21:0] line_drv_oe,
  input wire logic [21:0][2:0] rx_term,
  input wire logic [1:0] common_mode_voltage_out_oe
);
  timeunit 1ns / 1ns;
  // Every pin control lags its board pin by one edge.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rx_off; rx_differential_mode && !receive_impedance_pin |=> rx_hiz == '1 && rx_term == '0; endproperty
  a_rx_off: assert property (p_rx_off) else $error("receivers not off");
  property p_rx_on; rx_differential_mode && receive_impedance_pin |=> rx_hiz == '0; endproperty
  a_rx_on: assert property (p_rx_on) else $error("receivers still off");
  property p_drv_off; !output_enable_pin |=> line_drv_oe == '0; endproperty
  a_drv_off: assert property (p_drv_off) else $error("driver on, pin low");
  property p_cm_off; !common_mode_enable |=> common_mode_voltage_out_oe == '0; endproperty
  a_cm_off: assert property (p_cm_off) else $error("common mode on, pin low");
  property p_r120_off; rx_differential_mode && !receive_impedance_pin |=> rx_internal_120_ohm == '0; endproperty
  a_r120_off: assert property (p_r120_off) else $error("internal termination on");
  property p_se_on; !rx_differential_mode |=> rx_hiz == '0; endproperty
  a_se_on: assert property (p_se_on) else $error("receivers off in single-ended mode");
  property p_cm_on; common_mode_enable |=> common_mode_voltage_out_oe == '1; endproperty
  a_cm_on: assert property (p_cm_on) else $error("common mode off, pin high");
endmodule
bind gooc_top gooc_props i_props (.*);

// *** gooc_clk_src.sv ***
module gooc_clk_src (
  // Board clocks.
  input wire logic pclk,
  output logic [21:0] recovered_clk,
  output logic ext_clock_in_a,
  output logic ext_clock_in_b
);
  timeunit 1ns / 1ns;
  logic [3:0] cnt_q = 4'h0;
  // Unequal rates, so a wrong source pick shows another pattern.
  always @(posedge pclk)
    cnt_q <= cnt_q + 4'h1;
  // Channel three runs inverted, so a wrong channel pick shows too.
  assign recovered_clk = {22{cnt_q[0]}} ^ 22'h00_0008;
  assign ext_clock_in_a = cnt_q[3];
  assign ext_clock_in_b = cnt_q[1];
endmodule

// *** testbench.sv ***
`include "gooc_defs.svh"

module testbench;
  timeunit 1ns / 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er, ext_q, rec_q;
  logic receive_impedance_pin = 1'b1, output_enable_pin = 1'b1;
  logic common_mode_enable = 1'b0, rx_differential_mode = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, ext_clock_in_a, ext_clock_in_b, ref_clock_out_b, ref_b_oe;
  logic input_a_freq_select, input_b_freq_select;
  logic [21:0] recovered_clk, rx_hiz, rx_internal_120_ohm, line_drv_oe;
  logic [21:0][2:0] rx_term;
  logic [1:0] common_mode_voltage_out_oe;
  int fails = 0, comparisons = 0, cyc = 0;
  gooc_top i_dut (.*);
  gooc_clk_src i_src (.*);
  always #10 pclk = ~pclk;
  task automatic report_and_stop;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Cycle ceiling; the sequence needs about one hundred and thirty cycles.
  always @(posedge pclk)
  begin
    ext_q <= ext_clock_in_b;
    rec_q <= recovered_clk[3];
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      report_and_stop;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One transfer; a spare edge after release keeps the next setup apart.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_regs;
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk(er, 32'h1);
  endtask
  task automatic t_ref;
    logic prev;
    int tog;
    prev = 1'b0;
    tog = 0;
    apb(1'b1, 12'h000, 32'h0003_0020);
    apb(1'b1, 12'h004, 32'h0000_0061);
    chk(input_a_freq_select, 32'h1);
    chk(input_b_freq_select, 32'h1);
    chk(ref_b_oe, 32'h1);
    repeat (6)
    begin
      @(negedge pclk);
      chk(ref_clock_out_b, ext_q);
    end
    @(posedge pclk);
    apb(1'b1, 12'h004, 32'h0000_0340);
    repeat (6)
    begin
      @(negedge pclk);
      chk(ref_clock_out_b, rec_q);
    end
    @(posedge pclk);
    // Free source: four half periods give exactly four toggles.
    apb(1'b1, 12'h004, 32'h0000_0042);
    prev = ref_clock_out_b;
    repeat (4 * (`GOOC_FREE_HALF + 1))
    begin
      @(negedge pclk);
      if (ref_clock_out_b !== prev)
        tog++;
      prev = ref_clock_out_b;
    end
    chk(tog, 32'h4);
    @(posedge pclk);
    apb(1'b1, 12'h004, 32'h0000_0021);
    chk(ref_b_oe, 32'h0);
  endtask
  task automatic t_pins;
    rx_differential_mode <= 1'b1;
    receive_impedance_pin <= 1'b0;
    output_enable_pin <= 1'b0;
    apb(1'b1, 12'h008, 32'h0000_0315);
    apb(1'b1, 12'h00C, 32'h0000_0005);
    chk(rx_hiz, 32'h003F_FFFF);
    chk(rx_term[3], 32'h0);
    chk(rx_internal_120_ohm, 32'h0);
    chk(line_drv_oe, 32'h0);
    chk(common_mode_voltage_out_oe, 32'h0);
    // Settings stay reachable while the pins override them.
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0000_0015);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h0000_0005);
    receive_impedance_pin <= 1'b1;
    output_enable_pin <= 1'b1;
    common_mode_enable <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(rx_hiz, 32'h0);
    chk(rx_term[3], 32'h5);
    chk(rx_internal_120_ohm, 32'h0000_0008);
    chk(line_drv_oe, 32'h5);
    chk(common_mode_voltage_out_oe, 32'h3);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0000_0007);
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_ref;
    t_pins;
    report_and_stop;
  end
endmodule
